/* File: src/line_trig_pkg.sv */
// Purpose: shared constants for line trigger and exposure control
// Assumes: 250 MHz system clock
// Notes:   counts below are cycles of i_sys_clk
//
// What this block does
// - indicator amber while initialising, green once initialisation completes.
// - five trigger/exposure pairings; untriggered pulse-width is refused.
// - with trigger on, one line starts per accepted trigger.
// - triggered timed exposure must fit in the trigger period.
// - edge triggers use ascending or descending transition per polarity setting.
// - whole-period exposure lasts the full line period.
// - timed exposure ends after exposure_duration from line start.
// - trigger may target line_begin; input line selectable from all lines.
// - link outputs enabled per preferred link count.
// - pulse-width exposure lasts while input stays at selected active level.
// - without trigger, lines follow programmed rate; exposure capped at period.
package line_trig_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_MHZ      = 250;
  localparam int INIT_TIME_US = 100;
  localparam int INIT_CYCLES  = INIT_TIME_US * CLK_MHZ;
  // ****************************************************************
  // widths and encodings
  // ****************************************************************
  localparam int NUM_LINES = 16;
  localparam int NUM_LINKS = 4;
  localparam int CNT_W     = 32;
  localparam logic       TGT_LINE_BEGIN = 1'h1;
  localparam logic [1:0] POL_ASCENDING  = 2'h0;
  localparam logic [1:0] POL_DESCENDING = 2'h1;
  localparam logic [1:0] POL_HIGH_LEVEL = 2'h2;
  localparam logic [1:0] POL_LOW_LEVEL  = 2'h3;
  localparam logic [1:0] EXP_TIMED      = 2'h0;
  localparam logic [1:0] EXP_PULSE      = 2'h1;
  localparam logic [1:0] EXP_WHOLE      = 2'h2;
endpackage

/* File: src/pin_sync.sv */
// Purpose: three-stage synchroniser with agreement filter per input pin
// Assumes: inputs are asynchronous to i_sys_clk
// Notes:   level changes once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
  parameter int N = 16
) (
  // clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  // pins
  input  wire logic [N-1:0] i_async,
  // filtered levels
  output logic      [N-1:0] o_level
);
  // ****************************************************************
  // per-pin stages
  // ****************************************************************
  for (genvar g = 0; g < N; g++) begin : g_pin
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        s1_r       <= 1'b0;
        s2_r       <= 1'b0;
        s3_r       <= 1'b0;
        o_level[g] <= 1'b0;
      end else begin
        s1_r <= i_async[g];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          o_level[g] <= s3_r;
        end
      end
    end
  end
endmodule

/* File: src/line_trigger_exposure_control.sv */
// Purpose: line start and exposure timing for a line-scan sensor
// Assumes: configuration inputs are static while lines run
// Notes:   durations and periods are given in clock cycles
`timescale 1ns/1ps
module line_trigger_exposure_control #(
  parameter int INIT_CYCLES = line_trig_pkg::INIT_CYCLES,
  parameter int NUM_LINES   = line_trig_pkg::NUM_LINES,
  parameter int NUM_LINKS   = line_trig_pkg::NUM_LINKS,
  parameter int CNT_W       = line_trig_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  // trigger pins
  input  wire logic [NUM_LINES-1:0] i_trig_lines,
  // configuration
  input  wire logic                 i_trigger_enable,
  input  wire logic                 i_trigger_target_select,
  input  wire logic [3:0]           i_trigger_input_select,
  input  wire logic [1:0]           i_trigger_polarity_select,
  input  wire logic [1:0]           i_exposure_control_select,
  input  wire logic [CNT_W-1:0]     i_exposure_duration,
  input  wire logic [CNT_W-1:0]     i_free_run_line_period,
  input  wire logic [2:0]           i_preferred_link_config,
  // sensor timing
  output logic                      o_line_begin,
  output logic                      o_exposure_active,
  // status
  output logic                      o_indicator_amber,
  output logic                      o_indicator_green,
  output logic                      o_mode_error,
  output logic                      o_trigger_ignored,
  output logic [NUM_LINKS-1:0]      o_link_enable
);
  // ****************************************************************
  // types and signals
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_INIT   = 3'h1,
    ST_IDLE   = 3'h2,
    ST_EXPOSE = 3'h4
  } state_t;

  state_t               state_r;
  state_t               state_nxt;
  logic [NUM_LINES-1:0] lvl;
  logic                 sel_lvl;
  logic                 prev_lvl_r;
  logic [CNT_W-1:0]     init_cnt_r;
  logic [CNT_W-1:0]     line_cnt_r;
  logic [CNT_W-1:0]     exp_cnt_r;
  logic [CNT_W-1:0]     limit;
  logic                 trig_on;
  logic                 pw;
  logic                 whole;
  logic                 timed;
  logic                 bad;
  logic                 edge_evt;
  logic                 active_lvl;
  logic                 free_tick;
  logic                 start_evt;
  logic                 timed_done;
  logic                 ignored;

  pin_sync #(
    .N(NUM_LINES)
  ) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_trig_lines),
    .o_level   (lvl)
  );

  // ****************************************************************
  // trigger decode
  // ****************************************************************
  always_comb begin
    sel_lvl = 1'b0;
    if (32'(i_trigger_input_select) < NUM_LINES) begin
      sel_lvl = lvl[i_trigger_input_select];
    end
  end

  assign trig_on = i_trigger_enable &
                   (i_trigger_target_select == line_trig_pkg::TGT_LINE_BEGIN);
  assign pw    = i_exposure_control_select == line_trig_pkg::EXP_PULSE;
  assign whole = i_exposure_control_select == line_trig_pkg::EXP_WHOLE;
  assign timed = i_exposure_control_select == line_trig_pkg::EXP_TIMED;
  assign bad   = (~trig_on & pw) | ~(pw | whole | timed);

  always_comb begin
    edge_evt   = 1'b0;
    active_lvl = 1'b0;
    unique case (i_trigger_polarity_select)
      line_trig_pkg::POL_ASCENDING: begin
        edge_evt = trig_on & ~pw & sel_lvl & ~prev_lvl_r;
      end
      line_trig_pkg::POL_DESCENDING: begin
        edge_evt = trig_on & ~pw & ~sel_lvl & prev_lvl_r;
      end
      line_trig_pkg::POL_HIGH_LEVEL: begin
        active_lvl = trig_on & pw & sel_lvl;
      end
      line_trig_pkg::POL_LOW_LEVEL: begin
        active_lvl = trig_on & pw & ~sel_lvl;
      end
    endcase
  end

  // ****************************************************************
  // free-run line rate and exposure limit
  // ****************************************************************
  assign free_tick = ~trig_on & ~bad & (state_r != ST_INIT) &
                     (line_cnt_r + 1'b1 >= i_free_run_line_period);

  always_comb begin
    limit = i_exposure_duration;
    if (!trig_on && i_free_run_line_period < limit) begin
      limit = i_free_run_line_period;
    end
    if (limit == '0) begin
      limit = CNT_W'(1);
    end
  end

  assign timed_done = timed & (exp_cnt_r >= limit);
  assign start_evt  = trig_on ? (pw ? active_lvl : edge_evt)
                              : free_tick;
  assign ignored    = (state_r == ST_EXPOSE) & timed & trig_on &
                      edge_evt & ~timed_done;

  // ****************************************************************
  // line state machine
  // ****************************************************************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_INIT: begin
        if (init_cnt_r >= CNT_W'(INIT_CYCLES - 1)) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (start_evt && !bad) begin
          state_nxt = ST_EXPOSE;
        end
      end
      ST_EXPOSE: begin
        if (bad) begin
          state_nxt = ST_IDLE;
        end else if (pw && !active_lvl) begin
          state_nxt = ST_IDLE;
        end else if (free_tick) begin
          state_nxt = ST_EXPOSE;
        end else if (timed_done) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************************************
  // counters
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      init_cnt_r <= '0;
    end else if (state_r == ST_INIT) begin
      init_cnt_r <= init_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_cnt_r <= '0;
    end else if (trig_on || free_tick || state_r == ST_INIT) begin
      line_cnt_r <= '0;
    end else begin
      line_cnt_r <= line_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      exp_cnt_r <= '0;
    end else if (state_nxt == ST_EXPOSE && (state_r != ST_EXPOSE ||
                 free_tick || (whole && edge_evt))) begin
      exp_cnt_r <= CNT_W'(1);
    end else if (state_r == ST_EXPOSE && exp_cnt_r != '1) begin
      exp_cnt_r <= exp_cnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_lvl_r        <= 1'b0;
      o_line_begin      <= 1'b0;
      o_exposure_active <= 1'b0;
      o_trigger_ignored <= 1'b0;
      o_mode_error      <= 1'b0;
    end else begin
      prev_lvl_r        <= sel_lvl;
      o_line_begin      <= (state_nxt == ST_EXPOSE) &&
                           (state_r == ST_IDLE || free_tick ||
                            (whole && edge_evt));
      o_exposure_active <= state_nxt == ST_EXPOSE;
      o_trigger_ignored <= ignored;
      o_mode_error      <= bad;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_indicator_amber <= 1'b1;
      o_indicator_green <= 1'b0;
    end else begin
      o_indicator_amber <= state_nxt == ST_INIT;
      o_indicator_green <= state_nxt != ST_INIT;
    end
  end

  for (genvar k = 0; k < NUM_LINKS; k++) begin : g_link
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        o_link_enable[k] <= 1'b0;
      end else begin
        o_link_enable[k] <= 32'(i_preferred_link_config) > k;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_exp3;
    o_exposure_active [*3] ##1 !o_exposure_active;
  endsequence

  property p_indicator;
    $fell(o_indicator_amber) |-> o_indicator_green && $past(init_cnt_r) ==
      CNT_W'(INIT_CYCLES - 1);
  endproperty
  a_indicator: assert property (p_indicator)
    else $error("indicator left amber at wrong time");

  property p_bad_mode;
    (!trig_on && pw) |=> o_mode_error && !o_line_begin;
  endproperty
  a_bad_mode: assert property (p_bad_mode)
    else $error("untriggered pulse width not refused");

  property p_trig_line;
    (state_r == ST_IDLE && edge_evt && !bad)
      |=> o_line_begin && o_exposure_active;
  endproperty
  a_trig_line: assert property (p_trig_line)
    else $error("accepted trigger started no line");

  property p_wrong_edge;
    (state_r == ST_IDLE && trig_on && !pw && i_trigger_polarity_select ==
     line_trig_pkg::POL_DESCENDING && sel_lvl && !prev_lvl_r)
      |=> !o_line_begin;
  endproperty
  a_wrong_edge: assert property (p_wrong_edge)
    else $error("line started on wrong transition");

  property p_whole;
    (o_exposure_active && whole && trig_on) |=> o_exposure_active;
  endproperty
  a_whole: assert property (p_whole)
    else $error("whole-period exposure ended early");

  property p_timed3;
    (trig_on && timed && i_exposure_duration == CNT_W'(3) &&
     $rose(o_exposure_active)) |-> s_exp3;
  endproperty
  a_timed3: assert property (p_timed3)
    else $error("timed exposure length wrong");

  property p_pulse_end;
    (state_r == ST_EXPOSE && pw && trig_on && !active_lvl)
      |=> !o_exposure_active;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("pulse-width exposure outlived level");

  property p_free_rate;
    (o_line_begin && !trig_on && !bad && i_free_run_line_period ==
     CNT_W'(10)) |-> ##10 o_line_begin;
  endproperty
  a_free_rate: assert property (p_free_rate)
    else $error("free-run line period wrong");

  property p_ignore;
    ignored |=> o_trigger_ignored && !o_line_begin;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("trigger during exposure not ignored");
endmodule

/* File: verification/trig_source.sv */
// Purpose: far-side model, an external trigger source on the input lines
// Assumes: lines are driven at the rising edge of i_sys_clk
// Notes:   pulses invert one line for a width, then hold idle for a gap
`timescale 1ns/1ps
module trig_source (
  // clock
  input  wire logic        i_sys_clk,
  // trigger lines
  output logic      [15:0] o_lines
);
  // ****************************************************************
  // line driving
  // ****************************************************************
  initial begin
    o_lines = 16'h0000;
  end

  // idle level of every line
  task automatic set_idle(input logic lvl);
    @(posedge i_sys_clk);
    o_lines <= {16{lvl}};
  endtask

  // one pulse, then idle for the gap before any next pulse
  task automatic pulse(input int idx, input int width, input int gap);
    @(posedge i_sys_clk);
    o_lines[idx] <= ~o_lines[idx];
    repeat (width) @(posedge i_sys_clk);
    o_lines[idx] <= ~o_lines[idx];
    repeat (gap) @(posedge i_sys_clk);
  endtask
endmodule

/* File: verification/line_trigger_exposure_control_tb.sv */
// Purpose: self-checking bench for line trigger and exposure control
// Assumes: trigger source model on the input lines
// Notes:   line starts and exposure cycles are counted at the clock
`timescale 1ns/1ps
module line_trigger_exposure_control_tb;
  localparam int INIT = 10;
  logic        sys_clk, rst_n, trig_en, tgt;
  logic [15:0] lines;
  logic [3:0]  in_sel, link_en;
  logic [1:0]  pol, exp_sel;
  logic [31:0] dur, period;
  logic [2:0]  link_cfg;
  logic        line_begin, exp_act, amber, green, mode_err, ignored;
  int          miscompares, tests_run, n_beg, n_exp, n_ign, b0, e0, g0;

  trig_source u_trig_source (.i_sys_clk(sys_clk), .o_lines(lines));

  line_trigger_exposure_control #(.INIT_CYCLES(INIT))
    u_line_trigger_exposure_control (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_trig_lines(lines),
    .i_trigger_enable(trig_en), .i_trigger_target_select(tgt),
    .i_trigger_input_select(in_sel), .i_trigger_polarity_select(pol),
    .i_exposure_control_select(exp_sel), .i_exposure_duration(dur),
    .i_free_run_line_period(period), .i_preferred_link_config(link_cfg),
    .o_line_begin(line_begin), .o_exposure_active(exp_act),
    .o_indicator_amber(amber), .o_indicator_green(green),
    .o_mode_error(mode_err), .o_trigger_ignored(ignored),
    .o_link_enable(link_en));

  // ****************************************************************
  // clock, counters, helpers
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    if (line_begin === 1'b1) n_beg++;
    if (exp_act === 1'b1) n_exp++;
    if (ignored === 1'b1) n_ign++;
  end

  task automatic check(string what, logic [31:0] exp, logic [31:0] seen);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // set mode, let it settle, take counter snapshot
  task automatic cfg(logic en, logic [1:0] p, logic [1:0] e, int d, int per);
    @(posedge sys_clk);
    trig_en <= en;
    pol     <= p;
    exp_sel <= e;
    dur     <= 32'(d);
    period  <= 32'(per);
    u_trig_source.set_idle(p == line_trig_pkg::POL_DESCENDING ||
                           p == line_trig_pkg::POL_LOW_LEVEL);
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    b0 = n_beg;
    e0 = n_exp;
    g0 = n_ign;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_init();
    int n;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check("amber_in_reset", 1, amber);
    check("green_in_reset", 0, green);
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    n = 0;
    while (green !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    check("init_len_ok", 1, n >= INIT && n <= INIT + 3);
    check("amber_after_init", 0, amber);
  endtask

  task automatic t_links();
    for (int k = 0; k < 6; k++) begin
      @(posedge sys_clk);
      link_cfg <= 3'(k);
      repeat (3) @(negedge sys_clk);
      check("link_enable", k >= 4 ? 4'hf : 4'((1 << k) - 1), link_en);
    end
  endtask

  task automatic t_mode_err();
    cfg(0, line_trig_pkg::POL_ASCENDING, line_trig_pkg::EXP_PULSE, 3, 5);
    check("err_untrig_pulse", 1, mode_err);
    repeat (20) @(negedge sys_clk);
    check("err_no_lines", 0, n_beg - b0);
    cfg(0, line_trig_pkg::POL_ASCENDING, 2'h3, 3, 5);
    check("err_code3", 1, mode_err);
    cfg(1, line_trig_pkg::POL_ASCENDING, line_trig_pkg::EXP_PULSE, 3, 5);
    check("err_legal", 0, mode_err);
  endtask

  task automatic t_timed_edge(logic [1:0] p);
    cfg(1, p, line_trig_pkg::EXP_TIMED, 3, 5);
    u_trig_source.pulse(3, 6, 20);
    check("other_line_no_begin", 0, n_beg - b0);
    u_trig_source.pulse(5, 6, 20);
    u_trig_source.pulse(5, 6, 20);
    check("begin_per_trigger", 2, n_beg - b0);
    check("timed_exposure", 6, n_exp - e0);
  endtask

  task automatic t_ignore();
    cfg(1, line_trig_pkg::POL_ASCENDING, line_trig_pkg::EXP_TIMED, 40, 5);
    u_trig_source.pulse(5, 4, 6);
    u_trig_source.pulse(5, 4, 60);
    check("ignored_begins", 1, n_beg - b0);
    check("ignored_pulse", 1, n_ign - g0);
    check("ignored_exposure", 40, n_exp - e0);
  endtask

  task automatic t_pulse_width(logic [1:0] p);
    cfg(1, p, line_trig_pkg::EXP_PULSE, 3, 5);
    u_trig_source.pulse(5, 20, 20);
    check("pw_begins", 1, n_beg - b0);
    check("pw_exposure", 20, n_exp - e0);
  endtask

  task automatic t_whole_trig();
    cfg(1, line_trig_pkg::POL_ASCENDING, line_trig_pkg::EXP_WHOLE, 3, 5);
    u_trig_source.pulse(5, 4, 26);
    u_trig_source.pulse(5, 4, 26);
    @(negedge sys_clk);
    check("whole_trig_begins", 2, n_beg - b0);
    check("whole_trig_exposing", 1, exp_act);
  endtask

  task automatic t_free_run(logic t, logic [1:0] e, int d, int exp_cycles);
    @(posedge sys_clk);
    tgt <= t;
    cfg(!t, line_trig_pkg::POL_ASCENDING, e, d, 10);
    repeat (50) @(negedge sys_clk);
    check("free_begins", 5, n_beg - b0);
    check("free_exposure", exp_cycles, n_exp - e0);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    rst_n    = 1'b0;
    trig_en  = 1'b0;
    tgt      = line_trig_pkg::TGT_LINE_BEGIN;
    in_sel   = 4'h5;
    pol      = line_trig_pkg::POL_ASCENDING;
    exp_sel  = line_trig_pkg::EXP_TIMED;
    dur      = 32'h0000_0003;
    period   = 32'h0000_0010;
    link_cfg = 3'h0;
    t_init();
    t_links();
    t_mode_err();
    t_timed_edge(line_trig_pkg::POL_ASCENDING);
    t_timed_edge(line_trig_pkg::POL_DESCENDING);
    t_ignore();
    t_pulse_width(line_trig_pkg::POL_HIGH_LEVEL);
    t_pulse_width(line_trig_pkg::POL_LOW_LEVEL);
    t_whole_trig();
    t_free_run(1'b1, line_trig_pkg::EXP_WHOLE, 3, 50);
    t_free_run(1'b1, line_trig_pkg::EXP_TIMED, 4, 20);
    t_free_run(1'b0, line_trig_pkg::EXP_TIMED, 30, 50);
    conclude();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    conclude();
  end
endmodule
